// *** common/sal_pkg.sv ***
// What this block does
// - Device fail high while any failure flag
// - Sampling error flag follows its error
// - Settings check flag follows its error
// - Initialisation flag follows its error
// - Buffer overflow flag follows overflow condition
// - Sample buffer error flag follows error
// - Severe failure: block all, lamp off, contact
// - Minor abnormality blocks only affected functions
// - Failure: blocked, lamp_a off, alert on
// - Alarms: lamp_a stays on, alert on
// - Slot supply warning, 10s pick-up/drop-off
// - Self-check alarm on setting error/abnormal
// - Device alarm while any alarm active
package sal_pkg;

   // ****************************************************
   // Register bus
   // ****************************************************
   localparam int SAL_ADDR_W = 8;
   localparam int SAL_DATA_W = 32;

   localparam logic [SAL_ADDR_W-1:0] SAL_REG_STATUS = 8'h00;
   localparam logic [SAL_ADDR_W-1:0] SAL_REG_CLEAR  = 8'h04;
   localparam logic [SAL_ADDR_W-1:0] SAL_REG_ENABLE = 8'h08;
   localparam logic [SAL_ADDR_W-1:0] SAL_REG_STATE  = 8'h0c;

   // ****************************************************
   // Sizes and event bit layout
   // ****************************************************
   localparam int SAL_N_FAIL = 6;
   localparam int SAL_N_SLOT = 2;
   localparam int SAL_N_FUNC = 8;
   localparam int SAL_N_EVT  = 9;
   localparam int SAL_EVT_SLOT = 6;
   localparam int SAL_EVT_SELF = 8;
   localparam int SAL_STATE_FAIL  = 9;
   localparam int SAL_STATE_ALARM = 10;

   localparam logic [SAL_N_EVT-1:0]  SAL_EVT_RESET  = 9'h000;
   localparam logic [SAL_N_FUNC-1:0] SAL_FUNC_ALL   = 8'hff;
   localparam logic [SAL_N_FUNC-1:0] SAL_FUNC_NONE  = 8'h00;

   // ****************************************************
   // Timing
   // ****************************************************
   localparam int SAL_CLK_HZ         = 10_000_000;
   localparam int SAL_SUPPLY_DELAY_S = 10;
   localparam int SAL_SUPPLY_DELAY_CYC = SAL_SUPPLY_DELAY_S * SAL_CLK_HZ;
   localparam int SAL_DLY_W = 27;
   localparam logic [SAL_DLY_W-1:0] SAL_DLY_ZERO = 27'h0000000;
   localparam logic [SAL_DLY_W-1:0] SAL_DLY_ONE  = 27'h0000001;

   // ****************************************************
   // Carriers
   // ****************************************************
   typedef struct packed {
      logic sample_error;
      logic settings_error;
      logic init_error;
      logic logic_chip_damage;
      logic buffer_overflow;
      logic sample_buffer_error;
   } sal_fail_t;

   typedef struct packed {
      logic [SAL_ADDR_W-1:0] addr;
      logic [SAL_DATA_W-1:0] wdata;
      logic                  wr;
      logic                  rd;
   } sal_bus_req_t;

   typedef struct packed {
      logic lamp_a;
      logic alert_lamp;
      logic failure_output_contact;
   } sal_ind_t;

endpackage : sal_pkg

// *** design/sal_aggregator.sv ***
// The register addresses and the strobed register port were decided locally.
module sal_aggregator #(
   parameter int SUPPLY_DELAY_CYC = sal_pkg::SAL_SUPPLY_DELAY_CYC
) (
   input  wire logic                               sys_clk,                 // System clock
   input  wire logic                               rstn,                    // Sync reset, low
   input  wire logic                               ce,                      // Clock enable
   input  wire sal_pkg::sal_fail_t                 fail_cond,               // Raw failure causes
   input  wire logic                               setting_error,           // Setting error seen
   input  wire logic                               device_abnormal,         // Other abnormality
   input  wire logic [sal_pkg::SAL_N_FUNC-1:0]     minor_block,             // Minor fault targets
   input  wire logic [sal_pkg::SAL_N_SLOT-1:0]     supply_abnormal,         // Slot 05, 07 supply
   input  wire sal_pkg::sal_bus_req_t              bus_req,                 // Register request
   output logic [sal_pkg::SAL_DATA_W-1:0]          rdata,                   // Read data
   output sal_pkg::sal_fail_t                      fail_flag,               // Registered failures
   output logic                                    device_fail,             // Fail summary
   output logic                                    device_alarm,            // Alarm summary
   output logic                                    self_check_alarm,        // Self-check alarm
   output logic [sal_pkg::SAL_N_SLOT-1:0]          input_module_supply_warning, // Delayed warn
   output logic [sal_pkg::SAL_N_FUNC-1:0]          function_block,          // Blocked functions
   output sal_pkg::sal_ind_t                       ind,                     // Lamps and contact
   output logic                                    irq                      // Interrupt, high
);
   import sal_pkg::*;

   // ****************************************************
   // Delay limit
   // ****************************************************
   // The count stops one short because the state flip takes the last cycle
   localparam logic [SAL_DLY_W-1:0] DLY_LAST = SAL_DLY_W'(SUPPLY_DELAY_CYC - 1);

   // ****************************************************
   // Declarations
   // ****************************************************
   logic [SAL_N_EVT-1:0]  status;
   logic [SAL_N_EVT-1:0]  irq_enable;
   logic [SAL_N_EVT-1:0]  evt_now;
   logic [SAL_N_EVT-1:0]  evt_prev;
   logic [SAL_N_EVT-1:0]  evt_rise;
   logic [SAL_N_EVT-1:0]  clr_mask;
   logic [SAL_N_EVT-1:0]  next_status;
   logic                  wr_clear;
   logic                  wr_enable;
   logic                  any_fail;
   logic                  any_alarm;
   logic                  self_check_raw;
   logic [SAL_DATA_W-1:0] next_rdata;

   // ****************************************************
   // Failure flags
   // ****************************************************
   // Each flag is set the cycle its cause is seen and holds exactly as long
   // as the cause stays; software cannot clear a flag while its cause persists.
   always_ff @(posedge sys_clk) begin
      if (!rstn) begin
         fail_flag <= '0;
      end else if (ce) begin
         fail_flag.sample_error        <= fail_cond.sample_error;
         fail_flag.settings_error      <= fail_cond.settings_error;
         fail_flag.init_error          <= fail_cond.init_error;
         fail_flag.logic_chip_damage   <= fail_cond.logic_chip_damage;
         fail_flag.buffer_overflow     <= fail_cond.buffer_overflow;
         fail_flag.sample_buffer_error <= fail_cond.sample_buffer_error;
      end
   end

   assign any_fail = |fail_flag;

   // ****************************************************
   // Supply warnings with pick-up and drop-off delay
   // ****************************************************
   genvar g;
   generate
      for (g = 0; g < SAL_N_SLOT; g++) begin : g_slot
         logic [SAL_DLY_W-1:0] dly_cnt;

         always_ff @(posedge sys_clk) begin
            if (!rstn) begin
               dly_cnt                        <= SAL_DLY_ZERO;
               input_module_supply_warning[g] <= 1'b0;
            end else if (ce) begin
               if (supply_abnormal[g] == input_module_supply_warning[g]) begin
                  // Condition went back before the delay ran out
                  dly_cnt <= SAL_DLY_ZERO;
               end else if (dly_cnt == DLY_LAST) begin
                  dly_cnt                        <= SAL_DLY_ZERO;
                  input_module_supply_warning[g] <= supply_abnormal[g];
               end else begin
                  dly_cnt <= dly_cnt + SAL_DLY_ONE;
               end
            end
         end
      end
   endgenerate

   // ****************************************************
   // Alarm class
   // ****************************************************
   assign self_check_raw = setting_error | device_abnormal;

   always_ff @(posedge sys_clk) begin
      if (!rstn) begin
         self_check_alarm <= 1'b0;
      end else if (ce) begin
         self_check_alarm <= self_check_raw;
      end
   end

   assign any_alarm = self_check_alarm | (|input_module_supply_warning);

   // ****************************************************
   // Summaries, blocking and indicators
   // ****************************************************
   // All summaries are one cycle behind the flags so every output is a
   // flip-flop; a glitch-free contact matters more than one cycle of latency.
   always_ff @(posedge sys_clk) begin
      if (!rstn) begin
         device_fail  <= 1'b0;
         device_alarm <= 1'b0;
      end else if (ce) begin
         device_fail  <= any_fail;
         device_alarm <= any_alarm;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!rstn) begin
         function_block <= SAL_FUNC_NONE;
      end else if (ce) begin
         if (any_fail) begin
            function_block <= SAL_FUNC_ALL;
         end else begin
            // Alarms alone never block; only the minor fault's own targets do
            function_block <= minor_block;
         end
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!rstn) begin
         ind.lamp_a                 <= 1'b1;
         ind.alert_lamp             <= 1'b0;
         ind.failure_output_contact <= 1'b0;
      end else if (ce) begin
         ind.lamp_a                 <= ~any_fail;
         ind.alert_lamp             <= any_fail | any_alarm;
         ind.failure_output_contact <= any_fail;
      end
   end

   // ****************************************************
   // Event status and interrupt
   // ****************************************************
   assign evt_now = {self_check_alarm, input_module_supply_warning, fail_flag};
   assign evt_rise = evt_now & ~evt_prev;

   assign wr_clear  = bus_req.wr && (bus_req.addr == SAL_REG_CLEAR);
   assign wr_enable = bus_req.wr && (bus_req.addr == SAL_REG_ENABLE);
   assign clr_mask  = wr_clear ? bus_req.wdata[SAL_N_EVT-1:0] : SAL_EVT_RESET;

   // A rising event in the clearing cycle survives the clear
   assign next_status = (status & ~clr_mask) | evt_rise;

   always_ff @(posedge sys_clk) begin
      if (!rstn) begin
         evt_prev <= SAL_EVT_RESET;
         status   <= SAL_EVT_RESET;
      end else if (ce) begin
         evt_prev <= evt_now;
         status   <= next_status;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!rstn) begin
         irq_enable <= SAL_EVT_RESET;
      end else if (ce && wr_enable) begin
         irq_enable <= bus_req.wdata[SAL_N_EVT-1:0];
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!rstn) begin
         irq <= 1'b0;
      end else if (ce) begin
         irq <= |(next_status & irq_enable);
      end
   end

   // ****************************************************
   // Register read
   // ****************************************************
   always_comb begin
      next_rdata = '0;
      if (bus_req.addr == SAL_REG_STATUS) begin
         next_rdata[SAL_N_EVT-1:0] = status;
      end else if (bus_req.addr == SAL_REG_ENABLE) begin
         next_rdata[SAL_N_EVT-1:0] = irq_enable;
      end else if (bus_req.addr == SAL_REG_STATE) begin
         next_rdata[SAL_N_EVT-1:0]     = evt_now;
         next_rdata[SAL_STATE_FAIL]    = device_fail;
         next_rdata[SAL_STATE_ALARM]   = device_alarm;
      end
   end

   // Read data stand only in the cycle after the strobe, zero otherwise
   always_ff @(posedge sys_clk) begin
      if (!rstn) begin
         rdata <= '0;
      end else if (ce) begin
         rdata <= bus_req.rd ? next_rdata : '0;
      end
   end

endmodule : sal_aggregator

// *** testbench/sal_aggregator_sva.sv ***
module sal_aggregator_sva
   import sal_pkg::*;
#(
   parameter int SUPPLY_DELAY_CYC = 20
) (
   input wire logic                   sys_clk,                     // Clock
   input wire logic                   rstn,                        // Reset, low
   input wire logic                   ce,                          // Clock enable
   input wire sal_fail_t              fail_cond,                   // Raw causes
   input wire logic                   setting_error,               // Setting error
   input wire logic                   device_abnormal,             // Abnormal
   input wire logic [SAL_N_FUNC-1:0]  minor_block,                 // Minor targets
   input wire logic [SAL_N_SLOT-1:0]  supply_abnormal,             // Slot supply
   input wire sal_bus_req_t           bus_req,                     // Bus request
   input wire logic [SAL_DATA_W-1:0]  rdata,                       // Read data
   input wire sal_fail_t              fail_flag,                   // Flags
   input wire logic                   device_fail,                 // Fail summary
   input wire logic                   device_alarm,                // Alarm summary
   input wire logic                   self_check_alarm,            // Self-check
   input wire logic [SAL_N_SLOT-1:0]  input_module_supply_warning, // Warnings
   input wire logic [SAL_N_FUNC-1:0]  function_block,              // Blocked
   input wire sal_ind_t               ind,                         // Lamps
   input wire logic                   irq                          // Interrupt
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!rstn);

   flag_follow_a: assert property (ce |=> fail_flag == $past(fail_cond))
      else $error("fail_flag does not follow its cause");
   fail_sum_a: assert property (ce |=> device_fail == $past(|fail_flag))
      else $error("device_fail wrong");
   lamp_a_lamp_a: assert property (ce |=> ind.lamp_a == !$past(|fail_flag))
      else $error("lamp_a lamp wrong");
   fail_contact_a: assert property (ce |=> ind.failure_output_contact == $past(|fail_flag))
      else $error("failure contact wrong");
   fail_alert_a: assert property (ce && (|fail_flag) |=> ind.alert_lamp)
      else $error("alert lamp off on failure");
   func_block_a: assert property (ce |=> function_block ==
      ($past(|fail_flag) ? SAL_FUNC_ALL : $past(minor_block)))
      else $error("function_block wrong");
   self_check_a: assert property (ce |=> self_check_alarm == $past(setting_error | device_abnormal))
      else $error("self_check_alarm wrong");
   alarm_sum_a: assert property (ce |=>
      device_alarm == $past(self_check_alarm | (|input_module_supply_warning)))
      else $error("device_alarm wrong");
   warn_restart_a: assert property (ce && supply_abnormal == input_module_supply_warning
      |=> $stable(input_module_supply_warning))
      else $error("supply warning flipped without a full delay");
endmodule : sal_aggregator_sva

bind sal_aggregator sal_aggregator_sva #(.SUPPLY_DELAY_CYC(SUPPLY_DELAY_CYC)) u_sva (.*);

// *** testbench/sal_tb.sv ***
module tb;
   import sal_pkg::*;
   timeunit 1ns;
   timeprecision 1ns;
   localparam int N = 20;
   // Rows: {fail_cond, setting_error, device_abnormal, minor_block}
   localparam logic [15:0] ROW_IN [10] = '{16'h805a, 16'h405a, 16'h205a, 16'h105a,
      16'h085a, 16'h045a, 16'h005a, 16'h0200, 16'h0100, 16'hfe0f};
   // Rows: {device_fail, function_block, lamps, self_check_alarm}
   localparam logic [12:0] ROW_EXP [10] = '{13'h1ff6, 13'h1ff6, 13'h1ff6, 13'h1ff6,
      13'h1ff6, 13'h1ff6, 13'h05a8, 13'h000d, 13'h000d, 13'h1ff7};
   logic                  sys_clk, rstn, ce, setting_error, device_abnormal;
   logic                  device_fail, device_alarm, self_check_alarm, irq;
   logic [SAL_N_FUNC-1:0] minor_block, function_block;
   logic [SAL_N_SLOT-1:0] supply_abnormal, warn;
   logic [SAL_DATA_W-1:0] rdata;
   sal_fail_t             fail_cond, fail_flag;
   sal_bus_req_t          bus_req;
   sal_ind_t              ind;
   int                    errors, compares;

   sal_aggregator #(.SUPPLY_DELAY_CYC(N)) u_dut (.sys_clk(sys_clk), .rstn(rstn), .ce(ce),
      .fail_cond(fail_cond), .setting_error(setting_error), .device_abnormal(device_abnormal),
      .minor_block(minor_block), .supply_abnormal(supply_abnormal), .bus_req(bus_req),
      .rdata(rdata), .fail_flag(fail_flag), .device_fail(device_fail),
      .device_alarm(device_alarm), .self_check_alarm(self_check_alarm),
      .input_module_supply_warning(warn), .function_block(function_block), .ind(ind), .irq(irq));

   initial begin
      sys_clk = 1'b0;
      forever #50 sys_clk = ~sys_clk;
   end

   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      compares++;
      if (g !== e) begin
         errors++;
         $display("Error at %0t: got %h expected %h", $time, g, e);
      end
   endtask : chk

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge sys_clk) bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge sys_clk) bus_req.wr <= 1'b0;
   endtask : wr

   task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
      @(posedge sys_clk) bus_req <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
      @(posedge sys_clk) bus_req.rd <= 1'b0;
      @(negedge sys_clk) chk(rdata, e);
   endtask : rd_chk

   task automatic wait_chk(input int n, input logic [31:0] g_sel, input logic [31:0] e);
      repeat (n) @(posedge sys_clk);
      @(negedge sys_clk) chk({warn, device_alarm, ind.lamp_a, ind.alert_lamp}, e);
   endtask : wait_chk

   task automatic test_done;
      if (errors == 0 && compares > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask : test_done

   initial begin
      repeat (3000) @(posedge sys_clk);
      errors++;
      test_done;
   end

   initial begin
      {rstn, ce, setting_error, device_abnormal, minor_block, supply_abnormal} = '0;
      fail_cond = '0;
      bus_req = '0;
      repeat (8) @(posedge sys_clk);
      rstn <= 1'b1;
      ce <= 1'b1;
      for (int i = 0; i < 10; i++) begin
         @(posedge sys_clk) {fail_cond, setting_error, device_abnormal, minor_block} <= ROW_IN[i];
         repeat (4) @(posedge sys_clk);
         @(negedge sys_clk) chk({fail_flag, device_fail, function_block, ind, self_check_alarm},
            {ROW_IN[i][15:10], ROW_EXP[i]});
      end
      rd_chk(SAL_REG_STATUS, 32'h13f);
      rd_chk(SAL_REG_STATE, 32'h73f);
      wr(SAL_REG_STATUS, 32'h0);
      wr(SAL_REG_ENABLE, 32'h1ff);
      rd_chk(SAL_REG_ENABLE, 32'h1ff);
      rd_chk(SAL_REG_STATUS, 32'h13f);
      chk(irq, 1'b1);
      wr(SAL_REG_CLEAR, 32'h1ff);
      rd_chk(SAL_REG_STATUS, 32'h0);
      chk(irq, 1'b0);
      rd_chk(SAL_REG_CLEAR, 32'h0);
      rd_chk(8'h10, 32'h0);
      wr(SAL_REG_ENABLE, 32'h0);
      @(posedge sys_clk) {fail_cond, setting_error, device_abnormal, minor_block} <= '0;
      @(posedge sys_clk) fail_cond <= 6'h01;
      // Flag and sticky bit need two edges before the read strobe is sampled
      @(posedge sys_clk);
      rd_chk(SAL_REG_STATUS, 32'h001);
      chk(irq, 1'b0);
      wr(SAL_REG_ENABLE, 32'h001);
      // The new enable reaches irq one edge after the write is taken
      @(posedge sys_clk);
      @(negedge sys_clk) chk(irq, 1'b1);
      wr(SAL_REG_CLEAR, 32'h001);
      @(negedge sys_clk) chk(irq, 1'b0);
      @(posedge sys_clk) fail_cond <= '0;
      // Short burst first so a counter that fails to restart flips too early
      @(posedge sys_clk) supply_abnormal <= 2'b11;
      repeat (10) @(posedge sys_clk);
      supply_abnormal <= 2'b00;
      @(posedge sys_clk) supply_abnormal <= 2'b11;
      wait_chk(N - 2, 0, 32'h02);
      wait_chk(6, 0, 32'h1f);
      @(posedge sys_clk) supply_abnormal <= 2'b00;
      wait_chk(N - 2, 0, 32'h1f);
      wait_chk(6, 0, 32'h02);
      @(posedge sys_clk) ce <= 1'b0;
      fail_cond <= 6'h3f;
      repeat (3) @(posedge sys_clk);
      @(negedge sys_clk) chk(fail_flag, 6'h00);
      @(posedge sys_clk) ce <= 1'b1;
      repeat (4) @(posedge sys_clk);
      rstn <= 1'b0;
      repeat (2) @(posedge sys_clk);
      @(negedge sys_clk) chk({fail_flag, device_fail, function_block, ind, irq, warn},
         {6'h00, 1'b0, 8'h00, 3'b100, 1'b0, 2'b00});
      rstn <= 1'b1;
      test_done;
   end
endmodule : tb
